// >>> rtl/btg_top.sv
// Buzzer tone generator with APB register slave
`timescale 1ns/100ps
`default_nettype none
`include "btg_consts.svh"

module btg_top (
   input wire logic core_clk,
   input wire logic rstn,
   input wire btg_pkg::btg_apb_req_type apb_req,
   output var btg_pkg::btg_apb_rsp_type apb_rsp,
   input wire logic slow_osc_clock,
   output logic tone_out_p,
   output logic tone_out_n
);
   import btg_pkg::*;

   // ************************************************************
   // Functions
   // ************************************************************

   // Tone period in slow-clock half cycles
   function automatic logic [5:0] period_f(input logic [2:0] f);
      logic [5:0] b;
      b = 6'h00;
      case (f[1:0])
         2'h0: b = 6'h10;
         2'h1: b = 6'h14;
         2'h2: b = 6'h18;
         default: b = 6'h1c;
      endcase
      period_f = f[2] ? {b[4:0], 1'b0} : b;
   endfunction : period_f

   // High time in half cycles; low group uses 8-L, high group 12-L
   function automatic logic [5:0] high_f(input logic [2:0] f,
                                         input logic [2:0] l);
      logic [3:0] h;
      h = (f[1] ? 4'hc : 4'h8) - {1'b0, l};
      high_f = f[2] ? {1'b0, h, 1'b0} : {2'h0, h};
   endfunction : high_f

   function automatic logic [`BTG_TMR_W-1:0] limit_f(input logic [1:0] t);
      logic [`BTG_TMR_W-1:0] c;
      c = `BTG_CYC_T0;
      case (t)
         2'h0: c = `BTG_CYC_T0;
         2'h1: c = `BTG_CYC_T1;
         2'h2: c = `BTG_CYC_T2;
         default: c = `BTG_CYC_T3;
      endcase
      limit_f = c;
   endfunction : limit_f

   function automatic logic hit_f(input logic [`BTG_ADDR_W-1:0] a,
                                  input logic [`BTG_IDX_W-1:0] idx);
      hit_f = (a[`BTG_ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
   endfunction : hit_f

   // ************************************************************
   // Declarations
   // ************************************************************

   logic gate_q;
   logic [2:0] freq_q;
   logic [2:0] duty_q;
   btg_mode_type mode_q;
   logic [1:0] time_q;
   btg_state_type st_q;
   logic [`BTG_TMR_W-1:0] tmr_q;
   logic [2:0] env_q;
   logic [5:0] phase_q;
   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic slow_lvl_q;
   logic acc_first;
   logic acc_done;
   logic hit_clk;
   logic hit_ctl;
   logic hit_frq;
   logic hit_dty;
   logic mapped;
   logic wr_clk;
   logic wr_ctl;
   logic wr_frq;
   logic wr_dty;
   logic start;
   logic stop;
   logic half_tick;
   logic rise_tick;
   logic expire;
   logic active;
   logic [2:0] lvl_use;
   logic [5:0] period;
   logic [5:0] high;
   logic [31:0] rd_mux;

   // ************************************************************
   // APB decode
   // ************************************************************

   // Two-cycle access: pready rises in the second access cycle
   assign acc_first = apb_req.psel & apb_req.penable & ~apb_rsp.pready;
   assign acc_done = apb_req.psel & apb_req.penable & apb_rsp.pready;
   assign hit_clk = hit_f(apb_req.paddr, `BTG_IDX_CLK);
   assign hit_ctl = hit_f(apb_req.paddr, `BTG_IDX_CTL);
   assign hit_frq = hit_f(apb_req.paddr, `BTG_IDX_FRQ);
   assign hit_dty = hit_f(apb_req.paddr, `BTG_IDX_DTY);
   assign mapped = hit_clk | hit_ctl | hit_frq | hit_dty;
   assign wr_clk = acc_done & apb_req.pwrite & hit_clk;
   assign wr_ctl = acc_done & apb_req.pwrite & hit_ctl;
   assign wr_frq = acc_done & apb_req.pwrite & hit_frq;
   assign wr_dty = acc_done & apb_req.pwrite & hit_dty;
   assign start = wr_ctl & apb_req.pwdata[`BTG_CTL_EN_BIT];
   assign stop = wr_ctl & ~apb_req.pwdata[`BTG_CTL_EN_BIT];

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_clk) begin
         rd_mux[`BTG_CLK_GATE_BIT] = gate_q;
      end
      if (hit_ctl) begin
         rd_mux[`BTG_CTL_TIME_LO +: 2] = time_q;
         rd_mux[`BTG_CTL_MODE_LO +: 2] = mode_q;
         rd_mux[`BTG_CTL_EN_BIT] = (st_q != BTG_ST_IDLE);
      end
      if (hit_frq) begin
         rd_mux[2:0] = freq_q;
      end
      if (hit_dty) begin
         rd_mux[2:0] = duty_q;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready <= acc_first;
         apb_rsp.pslverr <= acc_first & ~mapped;
         apb_rsp.prdata <= (acc_first & ~apb_req.pwrite) ? rd_mux
                                                         : 32'h0000_0000;
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gate_q <= `BTG_RST_GATE;
         freq_q <= `BTG_RST_FREQ;
         duty_q <= `BTG_RST_DUTY;
         mode_q <= BTG_MD_NORM;
         time_q <= `BTG_RST_TIME;
      end else begin
         if (wr_clk) begin
            gate_q <= apb_req.pwdata[`BTG_CLK_GATE_BIT];
         end
         if (wr_ctl) begin
            mode_q <= btg_mode_type'(apb_req.pwdata[`BTG_CTL_MODE_LO +: 2]);
            time_q <= apb_req.pwdata[`BTG_CTL_TIME_LO +: 2];
         end
         if (wr_frq) begin
            freq_q <= apb_req.pwdata[2:0];
         end
         if (wr_dty) begin
            duty_q <= apb_req.pwdata[2:0];
         end
      end
   end

   // ************************************************************
   // Slow clock sampling
   // ************************************************************

   // Slow clock is a pin; sampled, not used as a clock edge
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         slow_lvl_q <= 1'b0;
      end else begin
         sync1_q <= slow_osc_clock;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q) begin
            slow_lvl_q <= sync2_q;
         end
      end
   end

   assign half_tick = gate_q & (sync2_q == sync3_q) &
                      (sync2_q != slow_lvl_q);
   assign rise_tick = half_tick & sync2_q;

   // ************************************************************
   // Mode sequencer
   // ************************************************************

   // duration in slow cycles; >= guards a shortened time field
   assign expire = rise_tick &
                   (tmr_q >= limit_f(time_q) - `BTG_TMR_W'(1));

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= BTG_ST_IDLE;
         tmr_q <= '0;
         env_q <= 3'h0;
      end else begin
         case (st_q)
            BTG_ST_IDLE: begin
               tmr_q <= '0;
            end
            BTG_ST_NORM: begin
               tmr_q <= '0;
            end
            BTG_ST_SHOT: begin
               if (rise_tick) begin
                  tmr_q <= tmr_q + `BTG_TMR_W'(1);
               end
               if (expire) begin
                  st_q <= BTG_ST_IDLE;
               end
            end
            BTG_ST_ENV: begin
               if (rise_tick) begin
                  tmr_q <= tmr_q + `BTG_TMR_W'(1);
               end
               if (expire) begin
                  tmr_q <= '0;
                  if (env_q == `BTG_LVL_MIN) begin
                     st_q <= BTG_ST_IDLE;
                  end else begin
                     env_q <= env_q + 3'h1;
                  end
               end
            end
            default: begin
               st_q <= BTG_ST_IDLE;
            end
         endcase
         if (stop) begin
            st_q <= BTG_ST_IDLE;
         end
         if (start) begin
            tmr_q <= '0;
            env_q <= 3'h0;
            case (btg_mode_type'(apb_req.pwdata[`BTG_CTL_MODE_LO +: 2]))
               BTG_MD_NORM: begin
                  st_q <= BTG_ST_NORM;
               end
               BTG_MD_SHOT: begin
                  st_q <= BTG_ST_SHOT;
               end
               BTG_MD_ENV: begin
                  st_q <= BTG_ST_ENV;
               end
               default: begin
                  st_q <= BTG_ST_IDLE;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Tone waveform
   // ************************************************************

   assign lvl_use = (st_q == BTG_ST_ENV) ? env_q : duty_q;
   assign period = period_f(freq_q);
   assign high = high_f(freq_q, lvl_use);
   assign active = (st_q != BTG_ST_IDLE);

   // Free-running divider, so start and stop are not phase aligned
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         phase_q <= 6'h00;
      end else if (half_tick) begin
         if (phase_q >= period - 6'h01) begin
            phase_q <= 6'h00;
         end else begin
            phase_q <= phase_q + 6'h01;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tone_out_p <= 1'b0;
         tone_out_n <= 1'b1;
      end else begin
         tone_out_p <= active & (phase_q < high);
         tone_out_n <= ~(active & (phase_q < high));
      end
   end

endmodule : btg_top
`default_nettype wire

// >>> shared/btg_consts.svh
// Constants of the buzzer tone generator: offsets, fields, resets, counts
`ifndef BTG_CONSTS_SVH
`define BTG_CONSTS_SVH

`define BTG_ADDR_W 20
`define BTG_IDX_W 18
`define BTG_IDX_CLK 18'h0506e
`define BTG_IDX_CTL 18'h05180
`define BTG_IDX_FRQ 18'h05181
`define BTG_IDX_DTY 18'h05182

`define BTG_CLK_GATE_BIT 0
`define BTG_CTL_EN_BIT 0
`define BTG_CTL_MODE_LO 2
`define BTG_CTL_TIME_LO 4

`define BTG_RST_GATE 1'h0
`define BTG_RST_FREQ 3'h0
`define BTG_RST_DUTY 3'h0
`define BTG_RST_TIME 2'h0
`define BTG_LVL_MIN 3'h7

`define BTG_TMR_W 13
`define BTG_CYC_T0 13'h0200
`define BTG_CYC_T1 13'h0400
`define BTG_CYC_T2 13'h0800
`define BTG_CYC_T3 13'h1000

`endif

// >>> shared/btg_pkg.sv
// Types of the buzzer tone generator
package btg_pkg;

   typedef enum logic [3:0] {
      BTG_ST_IDLE = 4'b0001,
      BTG_ST_NORM = 4'b0010,
      BTG_ST_SHOT = 4'b0100,
      BTG_ST_ENV = 4'b1000
   } btg_state_type;

   typedef enum logic [1:0] {
      BTG_MD_NORM = 2'h0,
      BTG_MD_SHOT = 2'h1,
      BTG_MD_ENV = 2'h2,
      BTG_MD_RSVD = 2'h3
   } btg_mode_type;

   typedef struct packed {
      logic [19:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
      logic psel;
      logic penable;
   } btg_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } btg_apb_rsp_type;

endpackage : btg_pkg

// >>> verif/btg_assertions.sv
// Port checker of the buzzer tone generator
`timescale 1ns/100ps
`default_nettype none
`include "btg_consts.svh"
module btg_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire btg_pkg::btg_apb_req_type apb_req,
   input wire btg_pkg::btg_apb_rsp_type apb_rsp,
   input wire logic tone_out_p,
   input wire logic tone_out_n
);
   import btg_pkg::*;
   logic [17:0] ix;
   logic hit;
   assign ix = apb_req.paddr[19:2];
   assign hit = apb_req.paddr[1:0] == 2'h0 && (ix == `BTG_IDX_CLK
      || ix == `BTG_IDX_CTL || ix == `BTG_IDX_FRQ || ix == `BTG_IDX_DTY);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ****
   // Bus and tone steps
   // ****
   sequence s_wait;
      apb_req.psel && apb_req.penable && !apb_rsp.pready;
   endsequence
   sequence s_off;
      apb_rsp.pready && apb_req.pwrite && hit && ix == `BTG_IDX_CTL
         && !apb_req.pwdata[0];
   endsequence
   a_out_compl: assert property (tone_out_n == !tone_out_p)
      else $error("outputs not complementary");
   a_reset_silent: assert property ($rose(rstn) |-> !tone_out_p)
      else $error("tone after reset");
   a_stop_silent: assert property (s_off |-> ##2 !tone_out_p)
      else $error("tone after stop");
   a_ready_time: assert property (s_wait |=> apb_rsp.pready)
      else $error("ready late");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready too long");
   a_ready_cause: assert property (apb_rsp.pready |-> $past(apb_req.penable))
      else $error("ready without access");
   a_err_map: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !hit)
      else $error("error flag wrong");
   a_idle_data: assert property (!apb_rsp.pready |-> apb_rsp.prdata == '0)
      else $error("read data outside answer");
   a_rsvd_zero: assert property (apb_rsp.pready && ix == `BTG_IDX_CTL
      |-> apb_rsp.prdata[31:6] == '0 && !apb_rsp.prdata[1])
      else $error("reserved bits set");
endmodule : btg_checker
bind btg_top btg_checker i_chk (.core_clk(core_clk), .rstn(rstn),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .tone_out_p(tone_out_p),
   .tone_out_n(tone_out_n));
`default_nettype wire

// >>> verif/btg_buzzer_model.sv
// Piezo buzzer load that measures drive period and high time
`timescale 1ns/100ps
`default_nettype none
module btg_buzzer_model (
   input wire logic core_clk,
   input wire logic drive_p,
   input wire logic drive_n,
   output logic [15:0] period,
   output logic [15:0] high_time,
   output logic meas_valid
);
   logic prev_q = 1'b0;
   logic [15:0] cnt_q = 16'h0;
   logic [15:0] hi_q = 16'h0;
   // Only opposed legs put voltage on the element
   always_ff @(posedge core_clk) begin
      prev_q <= drive_p;
      meas_valid <= drive_p && !prev_q;
      if (drive_p && !prev_q) begin
         period <= cnt_q;
         high_time <= hi_q;
         cnt_q <= 16'h1;
         hi_q <= 16'h1;
      end else begin
         cnt_q <= cnt_q + 16'h1;
         hi_q <= hi_q + {15'h0, drive_p && !drive_n};
      end
   end
endmodule : btg_buzzer_model
`default_nettype wire

// >>> verif/tb_buzzer_tone_generator.sv
// Self-checking bench of the buzzer tone generator
`timescale 1ns/100ps
`default_nettype none
`include "btg_consts.svh"
module tb_buzzer_tone_generator;
   import btg_pkg::*;
   // Slow clock sped up to six core cycles so timed modes fit the run
   localparam logic [15:0] SH = 16'h3;
   logic core_clk, rstn, tone_out_p, tone_out_n, meas_valid;
   logic slow_osc_clock = 1'b0;
   btg_apb_req_type req;
   btg_apb_rsp_type rsp;
   logic [15:0] period, high_time;
   logic [31:0] rq[$];
   logic [31:0] mq[$];
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int sc_n = 0;
   int i, t0;
   logic [16:0] rnd = 17'h176e3;
   logic [2:0] lv;
   btg_top i_dut (.core_clk(core_clk), .rstn(rstn), .apb_req(req),
      .apb_rsp(rsp), .slow_osc_clock(slow_osc_clock),
      .tone_out_p(tone_out_p), .tone_out_n(tone_out_n));
   btg_buzzer_model i_buz (.core_clk(core_clk), .drive_p(tone_out_p),
      .drive_n(tone_out_n), .period(period), .high_time(high_time),
      .meas_valid(meas_valid));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      sc_n <= (sc_n == 2) ? 0 : sc_n + 1;
      if (sc_n == 2) slow_osc_clock <= ~slow_osc_clock;
      if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && rq.size() > 0)
         chk(rsp.prdata, rq.pop_front());
      if (meas_valid === 1'b1 && mq.size() > 0)
         chk({period, high_time}, mq.pop_front());
   end
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic [17:0] ix, input logic w,
      input logic [31:0] d);
      req <= '{paddr: {ix, 2'h0}, pwrite: w, pwdata: d, psel: 1'b1,
         penable: 1'b0};
      @(posedge core_clk);
      req.penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hung access
      do begin
         @(posedge core_clk);
      end while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   task automatic rd(input logic [17:0] ix, input logic [31:0] e);
      rq.push_back(e);
      apb(ix, 1'b0, 32'h0);
   endtask : rd
   task automatic meas(input logic [2:0] f, input logic [2:0] l);
      logic [15:0] per;
      logic [15:0] hi;
      int n;
      per = (16'h10 + {12'h0, f[1:0], 2'h0}) << f[2];
      hi = ((f[1] ? 16'hc : 16'h8) - {13'h0, l}) << f[2];
      n = 0;
      repeat (400) @(posedge core_clk);
      mq.push_back({per * SH, hi * SH});
      while (mq.size() > 0 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
   endtask : meas
   task automatic wait_to(input int t);
      while (cyc < t) @(posedge core_clk);
   endtask : wait_to
   task automatic close_out;
      // Notes never matched by a result count as misses
      num_errors += rq.size() + mq.size();
      $display("compared %0d, wrong %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (95000) @(posedge core_clk);
      num_errors++;
      close_out();
   end
   // ****
   // Main sequence
   // ****
   initial begin
      rstn = 1'b0;
      req = '0;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      rd(`BTG_IDX_CLK, 32'h0);
      rd(`BTG_IDX_CTL, 32'h0);
      rd(`BTG_IDX_FRQ, 32'h0);
      rd(`BTG_IDX_DTY, 32'h0);
      rd(18'h05183, 32'h0);
      apb(`BTG_IDX_CLK, 1'b1, 32'h1);
      rd(`BTG_IDX_CLK, 32'h1);
      $display("test registers done");
      rnd = lfsr(rnd);
      for (i = 0; i < 8; i++) begin
         lv = 3'(i) + rnd[2:0];
         apb(`BTG_IDX_FRQ, 1'b1, {29'h0, 3'(i)});
         apb(`BTG_IDX_DTY, 1'b1, {29'h0, lv});
         if (i == 0) apb(`BTG_IDX_CTL, 1'b1, 32'h1);
         meas(3'(i), lv);
      end
      apb(`BTG_IDX_CTL, 1'b1, 32'h0);
      rd(`BTG_IDX_CTL, 32'h0);
      $display("test normal done");
      for (i = 0; i < 4; i++) begin
         apb(`BTG_IDX_CTL, 1'b1, {26'h0, 2'(i), 4'h5});
         t0 = cyc;
         rd(`BTG_IDX_CTL, {26'h0, 2'(i), 4'h5});
         meas(3'h7, lv);
         wait_to(t0 + (3072 << i) - 60);
         rd(`BTG_IDX_CTL, {26'h0, 2'(i), 4'h5});
         wait_to(t0 + (3072 << i) + 60);
         rd(`BTG_IDX_CTL, {26'h0, 2'(i), 4'h4});
      end
      apb(`BTG_IDX_CTL, 1'b1, 32'h5);
      wait_to(cyc + 2000);
      apb(`BTG_IDX_CTL, 1'b1, 32'h5);
      t0 = cyc;
      wait_to(t0 + 3012);
      rd(`BTG_IDX_CTL, 32'h5);
      wait_to(t0 + 3132);
      rd(`BTG_IDX_CTL, 32'h4);
      apb(`BTG_IDX_CTL, 1'b1, 32'h5);
      apb(`BTG_IDX_CTL, 1'b1, 32'h4);
      rd(`BTG_IDX_CTL, 32'h4);
      apb(`BTG_IDX_CTL, 1'b1, 32'hd);
      rd(`BTG_IDX_CTL, 32'hc);
      $display("test one-shot done");
      apb(`BTG_IDX_FRQ, 1'b1, 32'h0);
      apb(`BTG_IDX_DTY, 1'b1, 32'h7);
      apb(`BTG_IDX_CTL, 1'b1, 32'h9);
      t0 = cyc;
      meas(3'h0, 3'h0);
      wait_to(t0 + 10216);
      meas(3'h0, 3'h3);
      wait_to(t0 + 24516);
      rd(`BTG_IDX_CTL, 32'h9);
      wait_to(t0 + 24636);
      rd(`BTG_IDX_CTL, 32'h8);
      $display("test envelope done");
      // Gate off mid-tone: the timer must freeze, so the shot stays busy
      apb(`BTG_IDX_CTL, 1'b1, 32'h5);
      apb(`BTG_IDX_CLK, 1'b1, 32'h0);
      wait_to(cyc + 3200);
      rd(`BTG_IDX_CTL, 32'h5);
      apb(`BTG_IDX_CTL, 1'b1, 32'h4);
      rd(`BTG_IDX_CTL, 32'h4);
      $display("test gate done");
      close_out();
   end
endmodule : tb_buzzer_tone_generator
`default_nettype wire
